// ---- rtl/wdw_pkg.sv ----
/*
 Constants for the windowed watchdog: register indices, field
 positions, AXI responses and the timeout lookup.
 Assumes nothing; used by wdw_top only through wdw_pkg::name.
*/
package wdw_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [1:0] IDX_TIMEOUT_CTRL = 2'h0;
    localparam logic [1:0] IDX_WINDOW_CTRL = 2'h1;
    localparam logic [1:0] IDX_WD_STATE = 2'h2;
    // Field positions shared by both control registers, and the state sync bit
    localparam int CHG_BIT = 0;
    localparam int EN_BIT = 1;
    localparam int SEL_LO = 2;
    localparam int SEL_HI = 5;
    localparam int SYNC_BIT = 0;
    // AXI answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // System-clock cycles that a control write spends crossing over
    localparam logic [3:0] SYNC_CYC = 4'h3;
    // Counter width in bits; the counter counts reference ticks
    localparam int TICK_W = 14;
    // Phase states
    typedef enum logic [1:0] {
        PH_CLOSED = 2'b01,
        PH_OPEN = 2'b10
    } wdw_phase_e;

    // Period in 1 kHz ticks per select code; reserved codes take the longest
    function automatic logic [TICK_W-1:0] period_ticks(input logic [3:0] code);
        case (code)
            4'h0: period_ticks = 14'h0008;
            4'h1: period_ticks = 14'h0010;
            4'h2: period_ticks = 14'h0020;
            4'h3: period_ticks = 14'h0040;
            4'h4: period_ticks = 14'h007d;
            4'h5: period_ticks = 14'h00fa;
            4'h6: period_ticks = 14'h01f4;
            4'h7: period_ticks = 14'h03e8;
            4'h8: period_ticks = 14'h07d0;
            4'h9: period_ticks = 14'h0fa0;
            default: period_ticks = 14'h1f40;
        endcase
    endfunction
endpackage

// ---- rtl/wdw_top.sv ----
/*
 Windowed watchdog: two control registers and a state register on an
 AXI4-Lite slave, a tick counter with closed/open phases, reset request.
 Assumes ref_tick is a one-cycle pulse per 1 kHz reference period,
 synchronous to mclk, and that unlock_open marks the protected interval.
*/
`timescale 1ns/1ps

// Behaviour
// - Period counted in 1 kHz ticks; codes 0-10 give 8 ms to 8 s.
// - In window mode the timeout select gives the open window length.
// - Timeout select loads from the default period fuse at power-on.
// - Timeout select changes only when change unlock is written one.
// - Watchdog runs while enable is set; changing it needs change unlock.
// - Control bit 0 gates every control write; it resets to zero.
// - Lock fuse freezes control and closed select; window enable stays writable.
// - Closed window counted in 1 kHz ticks; codes 0-10 give 8 ms to 8 s.
// - Closed-window select loads from the default window fuse at power-on.
// - Normal mode ignores the closed-window select.
// - Closed select changes only when window change unlock is written one.
// - Window mode while window bit 1 set; changing it needs window unlock.
// - Window bit 0 gates every window write; it resets to zero.
// - State bit 0 reads one while a control write synchronises.
// - Synchronisation and its busy flag happen only while enabled.
// - State bits 7:1 read zero; software writes them zero.
// - Enabled and not restarted before timeout gives a reset request.
// - Restart during the closed period gives a reset request.
module wdw_top #(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Fuses and protection
    input wire logic [3:0] default_period_fuse,
    input wire logic [3:0] default_window_fuse,
    input wire logic default_enable_fuse,
    input wire logic default_wmode_fuse,
    input wire logic lock_fuse,
    input wire logic unlock_open,
    // Timing and restart
    input wire logic ref_tick,
    input wire logic watchdog_restart_instruction,
    // Reset request to the system
    output logic reset_request
);
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [7:0] wbyte_r, wbyte_nxt;
    logic aw_full_r, aw_full_nxt, w_full_r, w_full_nxt, wstrb0_r, wstrb0_nxt;
    logic awready_r, awready_nxt, wready_r, wready_nxt;
    logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0] timeout_select_r, timeout_select_nxt;
    logic [3:0] closed_window_select_r, closed_window_select_nxt;
    logic en_r, en_nxt, wmode_r, wmode_nxt;
    logic [3:0] busy_r, busy_nxt;
    logic domain_sync_pending_r, pend_nxt;
    logic do_wr, wr_ok, ctrl_ok, win_ok, aw_hi_ok, ar_hi_ok;
    logic [1:0] widx, ridx;

    // Write and read decode
    assign do_wr = aw_full_r && w_full_r && !bvalid_r;
    assign widx = awaddr_r[3:2];
    assign ridx = s_araddr[3:2];
    // Bits above the index must be zero; a shift stays legal when ADDR_W is 4
    assign aw_hi_ok = (awaddr_r >> 4) == '0;
    assign ar_hi_ok = (s_araddr >> 4) == '0;
    // writes outside the unlocked interval are dropped
    assign wr_ok = do_wr && wstrb0_r && unlock_open && aw_hi_ok;
    // control write gated by change unlock
    assign ctrl_ok = wr_ok && (widx == wdw_pkg::IDX_TIMEOUT_CTRL) && wbyte_r[wdw_pkg::CHG_BIT];
    // window write gated by window change unlock
    assign win_ok = wr_ok && (widx == wdw_pkg::IDX_WINDOW_CTRL) && wbyte_r[wdw_pkg::CHG_BIT];

    // AXI slave next state; address and data taken in either order
    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        awaddr_nxt = awaddr_r;
        wbyte_nxt = wbyte_r;
        wstrb0_nxt = wstrb0_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_awvalid && awready_r) begin
            aw_full_nxt = 1'b1;
            awaddr_nxt = s_awaddr;
        end
        if (s_wvalid && wready_r) begin
            w_full_nxt = 1'b1;
            wbyte_nxt = s_wdata[7:0];
            wstrb0_nxt = s_wstrb[0];
        end
        if (do_wr) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_hi_ok && widx <= wdw_pkg::IDX_WD_STATE)
                ? wdw_pkg::RESP_OKAY : wdw_pkg::RESP_SLVERR;
        end else if (bvalid_r && s_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = wdw_pkg::RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            if (!ar_hi_ok) begin
                rresp_nxt = wdw_pkg::RESP_SLVERR;
            end else begin
                unique case (ridx)
                    wdw_pkg::IDX_TIMEOUT_CTRL: begin
                        rdata_nxt[wdw_pkg::SEL_HI:wdw_pkg::SEL_LO] = timeout_select_r;
                        rdata_nxt[wdw_pkg::EN_BIT] = en_r;
                    end
                    wdw_pkg::IDX_WINDOW_CTRL: begin
                        rdata_nxt[wdw_pkg::SEL_HI:wdw_pkg::SEL_LO] = closed_window_select_r;
                        rdata_nxt[wdw_pkg::EN_BIT] = wmode_r;
                    end
                    wdw_pkg::IDX_WD_STATE: rdata_nxt[wdw_pkg::SYNC_BIT] = domain_sync_pending_r;
                    default: rresp_nxt = wdw_pkg::RESP_SLVERR;
                endcase
            end
        end else if (rvalid_r && s_rready) begin
            rvalid_nxt = 1'b0;
        end
        // Ready only while the holding slot is free and no answer waits
        awready_nxt = !aw_full_nxt && !bvalid_nxt;
        wready_nxt = !w_full_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // Configuration next state
    always_comb begin
        timeout_select_nxt = timeout_select_r;
        closed_window_select_nxt = closed_window_select_r;
        en_nxt = en_r;
        wmode_nxt = wmode_r;
        if (ctrl_ok && !lock_fuse) begin
            timeout_select_nxt = wbyte_r[wdw_pkg::SEL_HI:wdw_pkg::SEL_LO];
            en_nxt = wbyte_r[wdw_pkg::EN_BIT];
        end
        // window enable stays writable under lock
        if (win_ok) begin
            wmode_nxt = wbyte_r[wdw_pkg::EN_BIT];
            if (!lock_fuse) begin
                closed_window_select_nxt = wbyte_r[wdw_pkg::SEL_HI:wdw_pkg::SEL_LO];
            end
        end
        busy_nxt = (busy_r != 4'h0) ? busy_r - 4'h1 : 4'h0;
        if ((ctrl_ok || win_ok) && en_nxt) begin
            busy_nxt = wdw_pkg::SYNC_CYC;
        end
        pend_nxt = (busy_nxt != 4'h0);
    end

    // Bus and configuration registers; fuses load at power-on reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            awaddr_r <= '0;
            wbyte_r <= 8'h00;
            wstrb0_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= wdw_pkg::RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= wdw_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            timeout_select_r <= default_period_fuse;
            closed_window_select_r <= default_window_fuse;
            en_r <= default_enable_fuse;
            wmode_r <= default_wmode_fuse;
            busy_r <= 4'h0;
            domain_sync_pending_r <= 1'b0;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            awaddr_r <= awaddr_nxt;
            wbyte_r <= wbyte_nxt;
            wstrb0_r <= wstrb0_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            timeout_select_r <= timeout_select_nxt;
            closed_window_select_r <= closed_window_select_nxt;
            en_r <= en_nxt;
            wmode_r <= wmode_nxt;
            busy_r <= busy_nxt;
            domain_sync_pending_r <= pend_nxt;
        end
    end

    assign s_awready = awready_r;
    assign s_wready = wready_r;
    assign s_bvalid = bvalid_r;
    assign s_bresp = bresp_r;
    assign s_arready = arready_r;
    assign s_rvalid = rvalid_r;
    assign s_rresp = rresp_r;
    assign s_rdata = rdata_r;

    // Timer state
    wdw_pkg::wdw_phase_e phase_r, phase_nxt;
    logic [wdw_pkg::TICK_W-1:0] cnt_r, cnt_nxt, limit;
    logic reset_req_r, req_nxt, expire;

    // phase picks which select sets the limit
    assign limit = (phase_r == wdw_pkg::PH_CLOSED) ?
        wdw_pkg::period_ticks(closed_window_select_r) :
        wdw_pkg::period_ticks(timeout_select_r);
    assign expire = ref_tick && (cnt_r + 14'h0001 >= limit);

    // Timer next state; the request holds until system reset
    always_comb begin
        phase_nxt = phase_r;
        cnt_nxt = cnt_r;
        req_nxt = reset_req_r;
        if (!en_r) begin
            // Disabled: parked so enabling starts a fresh period
            cnt_nxt = '0;
            phase_nxt = wmode_r ? wdw_pkg::PH_CLOSED : wdw_pkg::PH_OPEN;
        end else if (watchdog_restart_instruction) begin
            if (wmode_r && phase_r == wdw_pkg::PH_CLOSED) begin
                req_nxt = 1'b1;
            end
            cnt_nxt = '0;
            phase_nxt = wmode_r ? wdw_pkg::PH_CLOSED : wdw_pkg::PH_OPEN;
        end else if (expire) begin
            cnt_nxt = '0;
            unique case (phase_r)
                wdw_pkg::PH_CLOSED: phase_nxt = wdw_pkg::PH_OPEN;
                wdw_pkg::PH_OPEN: req_nxt = 1'b1;
            endcase
        end else if (ref_tick) begin
            cnt_nxt = cnt_r + 14'h0001;
        end
    end

    // Timer registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            phase_r <= wdw_pkg::PH_OPEN;
            cnt_r <= '0;
            reset_req_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            reset_req_r <= req_nxt;
        end
    end

    assign reset_request = reset_req_r;

    // Checks on configuration, bus and timer
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_ctrl_gate: assert property (wr_ok && widx == wdw_pkg::IDX_TIMEOUT_CTRL
        && !wbyte_r[0] |=> $stable(timeout_select_r) && $stable(en_r))
        else $error("control changed without unlock bit");
    a_enable_write: assert property (ctrl_ok && !lock_fuse
        |=> en_r == $past(wbyte_r[1]))
        else $error("enable not taken from write");
    a_lock_freeze: assert property (lock_fuse && $past(lock_fuse)
        |-> $stable(timeout_select_r) && $stable(closed_window_select_r))
        else $error("locked field changed");
    a_win_gate: assert property (wr_ok && widx == wdw_pkg::IDX_WINDOW_CTRL
        && !wbyte_r[0] |=> $stable(closed_window_select_r) && $stable(wmode_r))
        else $error("window changed without unlock bit");
    a_wmode_write: assert property (win_ok |=> wmode_r == $past(wbyte_r[1]))
        else $error("window mode not taken from write");
    a_sync_flag: assert property ((ctrl_ok || win_ok) && en_nxt |=>
        domain_sync_pending_r [*3] ##1 (!domain_sync_pending_r || $past(ctrl_ok || win_ok)))
        else $error("busy flag length wrong");
    a_sync_off: assert property (busy_r == 4'h0 && !(en_nxt && (ctrl_ok || win_ok))
        |=> busy_r == 4'h0)
        else $error("busy without enable");
    a_state_zero: assert property (rvalid_r && rresp_r == wdw_pkg::RESP_OKAY
        && $past(ridx) == wdw_pkg::IDX_WD_STATE && $rose(rvalid_r) |-> rdata_r[31:1] == '0)
        else $error("state upper bits not zero");
    a_timeout_req: assert property (en_r && phase_r == wdw_pkg::PH_OPEN && expire
        && !watchdog_restart_instruction |=> reset_request)
        else $error("timeout missed");
    a_closed_req: assert property (en_r && wmode_r && phase_r == wdw_pkg::PH_CLOSED
        && watchdog_restart_instruction |=> reset_request)
        else $error("closed restart missed");
    a_restart_clr: assert property (en_r && watchdog_restart_instruction
        |=> cnt_r == '0)
        else $error("restart did not clear counter");
    a_normal_open: assert property (en_r && !wmode_r && watchdog_restart_instruction
        |=> phase_r == wdw_pkg::PH_OPEN)
        else $error("normal mode entered closed phase");

    c_window_ok: cover property (phase_r == wdw_pkg::PH_OPEN && wmode_r
        && watchdog_restart_instruction && !reset_request);
    c_timeout: cover property ($rose(reset_request));
    c_sync: cover property ($fell(domain_sync_pending_r));
endmodule

// ---- testbench/testbench.sv ----
/*
 Self-checking bench for wdw_top: AXI4-Lite register accesses, fuse
 defaults, protection, sync flag, normal and windowed timeouts.
 Assumes the package wdw_pkg and wdw_top are compiled first.
*/
`timescale 1ns/1ps

module testbench;
    // Clock, reset and design inputs, all defined at time zero
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] s_awaddr = 4'h0;
    logic s_awvalid = 1'b0;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'h1;
    logic s_wvalid = 1'b0;
    logic s_bready = 1'b0;
    logic [3:0] s_araddr = 4'h0;
    logic s_arvalid = 1'b0;
    logic s_rready = 1'b0;
    logic [3:0] default_period_fuse = 4'h5;
    logic [3:0] default_window_fuse = 4'h9;
    logic default_enable_fuse = 1'b0;
    logic default_wmode_fuse = 1'b0;
    logic lock_fuse = 1'b0;
    logic unlock_open = 1'b0;
    logic ref_tick = 1'b0;
    logic watchdog_restart_instruction = 1'b0;
    // Design outputs
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, reset_request;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    int fail_count = 0;
    int n_compared = 0;

    wdw_top wdw_top_inst (.mclk(mclk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .default_period_fuse(default_period_fuse), .default_window_fuse(default_window_fuse),
        .default_enable_fuse(default_enable_fuse), .default_wmode_fuse(default_wmode_fuse),
        .lock_fuse(lock_fuse), .unlock_open(unlock_open), .ref_tick(ref_tick),
        .watchdog_restart_instruction(watchdog_restart_instruction),
        .reset_request(reset_request));

    // 200 MHz clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Write one byte; address and data are released each on its own handshake
    task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= {24'h0, d};
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_awvalid && s_awready) begin
                s_awvalid <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                s_wvalid <= 1'b0;
            end
            if (s_bvalid === 1'b1) begin
                s_bready <= 1'b0;
                check("bresp", {30'h0, s_bresp}, {30'h0, er});
                break;
            end
        end
        if (n == 50) begin
            fail_count++;
            conclude();
        end
        // One edge apart, so a next call never re-drives bready in this step
        @(posedge mclk);
    endtask

    // Read a register and compare the response and, on OKAY, the whole word against the zero-extended byte
    task automatic axi_read(input logic [3:0] a, input logic [7:0] ed, input logic [1:0] er);
        int n;
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (s_arvalid && s_arready) begin
                s_arvalid <= 1'b0;
            end
            if (s_rvalid === 1'b1) begin
                s_rready <= 1'b0;
                check("rresp", {30'h0, s_rresp}, {30'h0, er});
                if (er == wdw_pkg::RESP_OKAY) begin
                    check("rdata", s_rdata, {24'h0, ed});
                end
                break;
            end
        end
        if (n == 50) begin
            fail_count++;
            conclude();
        end
        // One edge apart, so a next call never re-drives rready in this step
        @(posedge mclk);
    endtask

    // Reset held two cycles; fuses are sampled meanwhile
    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            ref_tick <= 1'b1;
            @(posedge mclk);
            ref_tick <= 1'b0;
            @(posedge mclk);
        end
        repeat (3) @(posedge mclk);
    endtask

    task automatic restart();
        watchdog_restart_instruction <= 1'b1;
        @(posedge mclk);
        watchdog_restart_instruction <= 1'b0;
        @(posedge mclk);
    endtask

    // Main sequence
    initial begin
        do_reset();
        axi_read(4'h0, 8'h14, wdw_pkg::RESP_OKAY);
        axi_read(4'h4, 8'h24, wdw_pkg::RESP_OKAY);
        axi_write(4'h8, 8'hff, wdw_pkg::RESP_OKAY);
        axi_read(4'h8, 8'h00, wdw_pkg::RESP_OKAY);
        $display("test defaults done");
        // Protection: closed interval, then missing change unlock
        axi_write(4'h0, 8'h03, wdw_pkg::RESP_OKAY);
        axi_read(4'h0, 8'h14, wdw_pkg::RESP_OKAY);
        unlock_open <= 1'b1;
        axi_write(4'h0, 8'h0a, wdw_pkg::RESP_OKAY);
        axi_read(4'h0, 8'h14, wdw_pkg::RESP_OKAY);
        // Byte lane 0 not strobed: the write must be dropped
        s_wstrb <= 4'h0;
        axi_write(4'h0, 8'h03, wdw_pkg::RESP_OKAY);
        s_wstrb <= 4'h1;
        axi_read(4'h0, 8'h14, wdw_pkg::RESP_OKAY);
        axi_write(4'h0, 8'h01, wdw_pkg::RESP_OKAY);
        axi_read(4'h8, 8'h00, wdw_pkg::RESP_OKAY);
        axi_write(4'h0, 8'h03, wdw_pkg::RESP_OKAY);
        axi_read(4'h8, 8'h01, wdw_pkg::RESP_OKAY);
        repeat (8) @(posedge mclk);
        axi_read(4'h8, 8'h00, wdw_pkg::RESP_OKAY);
        axi_read(4'h0, 8'h02, wdw_pkg::RESP_OKAY);
        // Every defined select code reads back
        for (int c = 10; c >= 0; c--) begin
            axi_write(4'h0, {2'b00, c[3:0], 2'b11}, wdw_pkg::RESP_OKAY);
            axi_read(4'h0, {2'b00, c[3:0], 2'b10}, wdw_pkg::RESP_OKAY);
        end
        $display("test control writes done");
        // Normal mode, 8 ticks; window select of 4000 ticks must not matter
        restart();
        tick(7);
        check("reset_request early", {31'h0, reset_request}, 32'h0);
        restart();
        tick(7);
        check("reset_request after restart", {31'h0, reset_request}, 32'h0);
        tick(1);
        check("reset_request expiry", {31'h0, reset_request}, 32'h1);
        $display("test normal timeout done");
        // Window mode from fuses, closed and open of 8 ticks each
        default_period_fuse <= 4'h0;
        default_window_fuse <= 4'h0;
        default_enable_fuse <= 1'b1;
        default_wmode_fuse <= 1'b1;
        do_reset();
        axi_read(4'h4, 8'h02, wdw_pkg::RESP_OKAY);
        restart();
        tick(3);
        restart();
        repeat (3) @(posedge mclk);
        check("reset_request closed", {31'h0, reset_request}, 32'h1);
        do_reset();
        restart();
        tick(8);
        restart();
        repeat (3) @(posedge mclk);
        check("reset_request open", {31'h0, reset_request}, 32'h0);
        tick(15);
        check("reset_request window", {31'h0, reset_request}, 32'h0);
        tick(1);
        check("reset_request late", {31'h0, reset_request}, 32'h1);
        $display("test window mode done");
        // Window register gating and lock fuse
        axi_write(4'h4, 8'h15, wdw_pkg::RESP_OKAY);
        axi_read(4'h4, 8'h14, wdw_pkg::RESP_OKAY);
        axi_write(4'h4, 8'h22, wdw_pkg::RESP_OKAY);
        axi_read(4'h4, 8'h14, wdw_pkg::RESP_OKAY);
        lock_fuse <= 1'b1;
        axi_write(4'h0, 8'h15, wdw_pkg::RESP_OKAY);
        axi_read(4'h0, 8'h02, wdw_pkg::RESP_OKAY);
        axi_write(4'h4, 8'h2b, wdw_pkg::RESP_OKAY);
        axi_read(4'h4, 8'h16, wdw_pkg::RESP_OKAY);
        axi_write(4'hc, 8'h01, wdw_pkg::RESP_SLVERR);
        axi_read(4'hc, 8'h00, wdw_pkg::RESP_SLVERR);
        $display("test lock and decode done");
        conclude();
    end
endmodule
